// file: logic/host_port_pkg.sv
// ==========================================================================
// Shared constants and types for both ends of the parallel host port.
// ==========================================================================
package host_port_pkg;

	// ======================================================================
	// Pin and data widths.
	// ======================================================================
	localparam int DATA_W = 16; // Full width of the host data bus.
	localparam int NARROW_W = 8; // Width used in 8-bit port mode.
	localparam int SYNC_STAGES = 2; // Flip-flops in each input synchroniser.

	// ======================================================================
	// Timing counts, in cycles of the 200 MHz clock.
	// ======================================================================
	localparam int CLOCK_MHZ = 200; // Core clock rate.
	localparam int ACCESS_NS = 20; // Least time the device is busy per access.
	localparam int ACCESS_CYCLES = (ACCESS_NS * CLOCK_MHZ + 999) / 1000;
	localparam int STROBE_CYCLES = 6; // Host strobe low time; beats sync lag.
	localparam int ADDR_CYCLES = 6; // Host address strobe low time.
	localparam logic [3:0] ACCESS_COUNT = 4'(ACCESS_CYCLES);
	localparam logic [3:0] STROBE_COUNT = 4'(STROBE_CYCLES);
	localparam logic [3:0] ADDR_COUNT = 4'(ADDR_CYCLES);

	// ======================================================================
	// Host controller register map on AXI4-Lite.
	// ======================================================================
	localparam logic [7:0] CONTROL_OFFSET = 8'h00; // Start and options.
	localparam logic [7:0] ADDRESS_OFFSET = 8'h04; // Address phase value.
	localparam logic [7:0] WDATA_OFFSET = 8'h08; // Data to write.
	localparam logic [7:0] STATUS_OFFSET = 8'h0C; // Busy, done, pin levels.
	localparam logic [7:0] RDATA_OFFSET = 8'h10; // Data read back.
	localparam int CTRL_START = 0; // Write 1 to start one transfer.
	localparam int CTRL_WRITE = 1; // 1 writes to the device, 0 reads.
	localparam int CTRL_ADDR = 2; // 1 runs an address strobe phase first.
	localparam int CTRL_SEL_LO = 3; // Two access-select bits at 4:3.
	localparam int CTRL_HALF = 5; // Byte-half select.
	localparam logic [1:0] AXI_OKAY = 2'h0; // Normal response.
	localparam logic [1:0] AXI_SLVERR = 2'h2; // Unmapped address.

	// Host controller sequence.
	typedef enum logic [2:0] {
		host_idle,
		host_addr,
		host_gap,
		host_wait_ready,
		host_strobe,
		host_finish
	} host_state_type;

endpackage

// file: logic/host_port_if.sv
`timescale 1ns/100ps
// ==========================================================================
// Pin bundle between host controller and device port. Each driver of a shared
// pin (data, ready, interrupt) has an output enable; the bench resolves the *_bus wires from them.
// ==========================================================================
interface host_port_if;
	import host_port_pkg::*;
	logic host_select_n; // Chip select, low during an access.
	logic data_strobe_a_n; // First data strobe.
	logic data_strobe_b_n; // Second data strobe.
	logic addr_strobe_n; // Address latch strobe.
	logic read_not_write; // High reads, low writes.
	logic access_select_0; // Register select, low bit.
	logic access_select_1; // Register select, high bit.
	logic byte_half_select; // First or second byte.
	logic [DATA_W-1:0] host_data; // Host data drive.
	logic host_data_oe; // Host drives the data bus.
	logic [DATA_W-1:0] dev_data; // Device data drive.
	logic dev_data_oe; // Device drives the data bus.
	logic port_ready_out; // Device ready drive.
	logic ready_oe; // Device drives ready.
	logic host_irq_n; // Device interrupt drive.
	logic irq_oe; // Device drives interrupt.
	logic [DATA_W-1:0] data_bus; // Resolved data level.
	logic ready_bus; // Resolved ready level.
	logic irq_bus; // Resolved interrupt level.

	modport host (
		output host_select_n, data_strobe_a_n, data_strobe_b_n,
		output addr_strobe_n, read_not_write, access_select_0,
		output access_select_1, byte_half_select, host_data, host_data_oe,
		input data_bus, ready_bus, irq_bus
	);
	modport device (
		input host_select_n, data_strobe_a_n, data_strobe_b_n,
		input addr_strobe_n, read_not_write, access_select_0,
		input access_select_1, byte_half_select, data_bus,
		output dev_data, dev_data_oe, port_ready_out, ready_oe,
		output host_irq_n, irq_oe
	);
endinterface

// file: logic/host_port_device.sv
`timescale 1ns/100ps
// ==========================================================================
// Device end of the parallel host port: straps, synchronisers, address
// capture, transfer sequencing, ready and interrupt pins.
// ==========================================================================

module host_port_device
	import host_port_pkg::*;
#(
	parameter int ACCESS_LEN = ACCESS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	host_port_if.device pins,
	input wire logic port_enable_strap,
	input wire logic wide_mode_strap,
	input wire logic outputs_off_n,
	input wire logic irq_request,
	input wire logic [DATA_W-1:0] core_rdata,
	output logic xfer_valid,
	output logic xfer_write,
	output logic [1:0] xfer_select,
	output logic xfer_half,
	output logic [DATA_W-1:0] xfer_wdata,
	output logic [DATA_W-1:0] host_address_reg,
	output logic port_enabled,
	output logic wide_mode,
	output logic pullup_enable,
	output logic holder_enable
);

	// ======================================================================
	// Input synchronisers.
	// ======================================================================
	localparam int NSYNC = 5; // Select, two strobes, address strobe, R/W.
	logic [NSYNC-1:0] raw_in; // Raw asynchronous host controls.
	logic [NSYNC-1:0] sync_meta; // First stage; read only by second stage.
	logic [NSYNC-1:0] sync_out; // Second stage, safe to use.
	logic [NSYNC-1:0] sync_prev; // Delayed copy for edge detection.
	logic strap_pending; // High until straps are caught after release.
	logic access_on; // Synchronised select and strobe both active.
	logic access_prev; // Previous value of access_on.
	logic addr_edge; // Address strobe has just gone low.
	logic access_edge; // An access has just begun.
	logic [3:0] busy_count; // Cycles left before ready returns.
	logic [3:0] access_len; // Busy length at register width.

	assign access_len = 4'(ACCESS_LEN);
	assign raw_in = {pins.read_not_write, pins.addr_strobe_n,
		pins.data_strobe_b_n, pins.data_strobe_a_n, pins.host_select_n};

	// Two flops per control so metastability settles before decoding.
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : gen_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync_meta[g] <= 1'b1;
					sync_out[g] <= 1'b1;
					sync_prev[g] <= 1'b1;
				end else begin
					sync_meta[g] <= raw_in[g];
					sync_out[g] <= sync_meta[g];
					sync_prev[g] <= sync_out[g];
				end
			end
		end
	endgenerate

	// An access needs select low and either strobe low; select alone or a
	// stray strobe with select high does nothing.
	assign access_on = port_enabled && !sync_out[0] &&
		!(sync_out[1] && sync_out[2]);
	assign access_edge = access_on && !access_prev;
	assign addr_edge = port_enabled && !sync_out[3] && sync_prev[3];

	// ======================================================================
	// Strap capture.
	// ======================================================================
	// Straps are caught on the first edge after reset release; the board
	// must keep them still afterwards, as later changes are never seen.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_pending <= 1'b1;
			port_enabled <= 1'b0;
			wide_mode <= 1'b0;
			pullup_enable <= 1'b1;
			holder_enable <= 1'b1;
		end else if (strap_pending) begin
			strap_pending <= 1'b0;
			port_enabled <= port_enable_strap;
			wide_mode <= wide_mode_strap;
			pullup_enable <= !port_enable_strap;
			holder_enable <= !port_enable_strap;
		end
	end

	// ======================================================================
	// Address capture.
	// ======================================================================
	// The address is taken from the bus three cycles into the strobe, by
	// which time a multiplexed host has long since settled it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_address_reg <= '0;
		end else if (addr_edge) begin
			if (wide_mode) begin
				host_address_reg <= pins.data_bus;
			end else begin
				host_address_reg <= {{(DATA_W-NARROW_W){1'b0}},
					pins.data_bus[NARROW_W-1:0]};
			end
		end
	end

	// ======================================================================
	// Transfer sequencing toward the core.
	// ======================================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			access_prev <= 1'b0;
			xfer_valid <= 1'b0;
			xfer_write <= 1'b0;
			xfer_select <= 2'h0;
			xfer_half <= 1'b0;
			xfer_wdata <= '0;
		end else begin
			access_prev <= access_on;
			xfer_valid <= access_edge && (busy_count == 4'h0);
			if (access_edge) begin
				xfer_write <= !sync_out[4];
				if (wide_mode) begin
					xfer_select <= 2'h0;
					xfer_half <= 1'b0;
					xfer_wdata <= pins.data_bus;
				end else begin
					xfer_select <= {pins.access_select_1,
						pins.access_select_0};
					xfer_half <= pins.byte_half_select;
					xfer_wdata <= {{(DATA_W-NARROW_W){1'b0}},
						pins.data_bus[NARROW_W-1:0]};
				end
			end
		end
	end

	// Busy counter: loaded by an accepted access, counts down to ready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_count <= 4'h0;
		end else if (access_edge && busy_count == 4'h0) begin
			busy_count <= access_len;
		end else if (busy_count != 4'h0) begin
			busy_count <= busy_count - 4'h1;
		end
	end

	// ======================================================================
	// Pin drivers.
	// ======================================================================
	// Ready and interrupt both sit high in reset; every enable follows the
	// global output-off input one cycle late, the price of flopped pins;
	// irq_oe follows it only outside wide mode and stays low in wide mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins.port_ready_out <= 1'b1;
			pins.ready_oe <= 1'b1;
			pins.host_irq_n <= 1'b1;
			pins.irq_oe <= 1'b1;
		end else begin
			pins.port_ready_out <= (busy_count == 4'h0) &&
				!(access_edge);
			pins.ready_oe <= outputs_off_n;
			pins.host_irq_n <= !(irq_request && !wide_mode);
			pins.irq_oe <= outputs_off_n && !wide_mode;
		end
	end

	// Read data is driven only while a read access is active.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins.dev_data <= '0;
			pins.dev_data_oe <= 1'b0;
		end else begin
			if (access_edge) begin
				pins.dev_data <= wide_mode ? core_rdata :
					{{(DATA_W-NARROW_W){1'b0}}, core_rdata[NARROW_W-1:0]};
			end
			pins.dev_data_oe <= access_on && sync_out[4] &&
				outputs_off_n;
		end
	end

endmodule // host_port_device

// file: logic/host_port_host.sv
`timescale 1ns/100ps
// ==========================================================================
// Host end: an AXI4-Lite register slave that runs one port transfer at a
// time on the parallel pins.
// ==========================================================================
module host_port_host
	import host_port_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	host_port_if.host pins,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ======================================================================
	// Registers.
	// ======================================================================
	logic [5:0] control; // Options and start bit, kept as written.
	logic [DATA_W-1:0] address; // Address for the address phase.
	logic [DATA_W-1:0] wdata; // Data to write.
	logic [DATA_W-1:0] rdata; // Data last read.
	logic done; // Sticky: transfer finished; cleared by a new start.
	host_state_type state; // Transfer sequencer state.
	logic [3:0] count; // Phase timer.
	logic wr_take; // Write address and data both taken now.
	logic start; // Software asked for a transfer.

	assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
		!s_axi_awready;
	assign start = wr_take && s_axi_awaddr == CONTROL_OFFSET &&
		s_axi_wstrb[0] && s_axi_wdata[CTRL_START];

	// Write channel: address and data taken together, then a response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
			control <= '0;
			address <= '0;
			wdata <= '0;
		end else begin
			s_axi_awready <= wr_take;
			s_axi_wready <= wr_take;
			if (wr_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= AXI_OKAY;
				unique case (s_axi_awaddr)
					CONTROL_OFFSET: begin
						if (state == host_idle) begin
							control <= s_axi_wdata[5:0];
						end
					end
					ADDRESS_OFFSET: address <= s_axi_wdata[DATA_W-1:0];
					WDATA_OFFSET: wdata <= s_axi_wdata[DATA_W-1:0];
					default: s_axi_bresp <= AXI_SLVERR;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one-cycle address accept, data on the same edge as arready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= AXI_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid &&
				!s_axi_arready;
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= AXI_OKAY;
				unique case (s_axi_araddr)
					CONTROL_OFFSET: s_axi_rdata <= {26'h0, control};
					ADDRESS_OFFSET: s_axi_rdata <= {16'h0, address};
					WDATA_OFFSET: s_axi_rdata <= {16'h0, wdata};
					STATUS_OFFSET: s_axi_rdata <= {28'h0, pins.irq_bus,
						pins.ready_bus, done, state != host_idle};
					RDATA_OFFSET: s_axi_rdata <= {16'h0, rdata};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Pin sequencer.
	// ======================================================================
	// Select is held low from the register phase to the end of the strobe,
	// and the strobe waits for ready, so a busy device is never pushed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= host_idle;
			count <= 4'h0;
			done <= 1'b0;
			rdata <= '0;
			pins.host_select_n <= 1'b1;
			pins.data_strobe_a_n <= 1'b1;
			pins.data_strobe_b_n <= 1'b1;
			pins.addr_strobe_n <= 1'b1;
			pins.read_not_write <= 1'b1;
			pins.access_select_0 <= 1'b0;
			pins.access_select_1 <= 1'b0;
			pins.byte_half_select <= 1'b0;
			pins.host_data <= '0;
			pins.host_data_oe <= 1'b0;
		end else begin
			unique case (state)
				host_idle: begin
					if (start) begin
						done <= 1'b0;
						pins.host_select_n <= 1'b0;
						pins.read_not_write <= !s_axi_wdata[CTRL_WRITE];
						pins.access_select_0 <= s_axi_wdata[CTRL_SEL_LO];
						pins.access_select_1 <= s_axi_wdata[CTRL_SEL_LO+1];
						pins.byte_half_select <= s_axi_wdata[CTRL_HALF];
						if (s_axi_wdata[CTRL_ADDR]) begin
							pins.host_data <= address;
							pins.host_data_oe <= 1'b1;
							pins.addr_strobe_n <= 1'b0;
							count <= ADDR_COUNT;
							state <= host_addr;
						end else begin
							state <= host_wait_ready;
						end
					end
				end
				host_addr: begin
					count <= count - 4'h1;
					if (count == 4'h1) begin
						pins.addr_strobe_n <= 1'b1;
						pins.host_data_oe <= 1'b0;
						state <= host_gap;
					end
				end
				host_gap: begin
					state <= host_wait_ready;
				end
				host_wait_ready: begin
					if (pins.ready_bus) begin
						pins.data_strobe_a_n <= 1'b0;
						pins.host_data <= wdata;
						pins.host_data_oe <= control[CTRL_WRITE];
						count <= STROBE_COUNT;
						state <= host_strobe;
					end
				end
				host_strobe: begin
					count <= count - 4'h1;
					if (count == 4'h1) begin
						if (!control[CTRL_WRITE]) begin
							rdata <= pins.data_bus;
						end
						pins.data_strobe_a_n <= 1'b1;
						pins.host_select_n <= 1'b1;
						pins.host_data_oe <= 1'b0;
						state <= host_finish;
					end
				end
				host_finish: begin
					done <= 1'b1;
					state <= host_idle;
				end
			endcase
		end
	end

endmodule // host_port_host

// file: tb/host_port_monitor.sv
`timescale 1ns/100ps
// ====================
// Pin checks on the link that joins the host and device ends.
// ====================
module host_port_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic outputs_off_n,
	input wire logic wide_mode,
	input wire logic host_select_n,
	input wire logic data_strobe_a_n,
	input wire logic addr_strobe_n,
	input wire logic read_not_write,
	input wire logic dev_data_oe,
	input wire logic port_ready_out,
	input wire logic ready_oe,
	input wire logic host_irq_n,
	input wire logic irq_oe,
	input wire logic ready_bus
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ====================
	// Assertions.
	// ====================
	// Reset values are still visible at the first edge after release.
	a_ready_reset: assert property (
		$rose(aresetn) |-> port_ready_out && ready_oe)
		else $error("ready was not driven high in reset");
	a_irq_reset: assert property (
		$rose(aresetn) |-> host_irq_n && irq_oe)
		else $error("interrupt was not driven high in reset");
	a_host_idle_reset: assert property (
		$rose(aresetn) |-> host_select_n && data_strobe_a_n &&
		addr_strobe_n)
		else $error("host pins not idle after reset");
	// The enables follow the output-off pin one edge late.
	a_outputs_float: assert property (
		!outputs_off_n && !$past(outputs_off_n) && $past(aresetn) |->
		!ready_oe && !irq_oe)
		else $error("outputs driven while output-off was low");
	a_wide_no_irq: assert property (
		wide_mode && $past(wide_mode) |-> host_irq_n && !irq_oe)
		else $error("interrupt pin used in wide mode");
	a_ready_access: assert property (
		$fell(port_ready_out) |-> !port_ready_out[*3] ##[1:4]
		port_ready_out)
		else $error("ready low time out of range");
	a_strobe_waits_ready: assert property (
		$fell(data_strobe_a_n) |-> $past(ready_bus))
		else $error("strobe fell while ready was low");
	a_select_covers: assert property (!data_strobe_a_n |-> !host_select_n)
		else $error("strobe low without chip select");
	a_rnw_steady: assert property (
		!data_strobe_a_n && !$past(data_strobe_a_n) |->
		$stable(read_not_write))
		else $error("direction changed inside a strobe");
	a_read_drives: assert property (dev_data_oe |-> read_not_write)
		else $error("device drove data on a write");
	// Two synchroniser stages stand between the strobe and any reaction.
	a_sync_delay: assert property (
		$fell(data_strobe_a_n) |-> !dev_data_oe[*2])
		else $error("device reacted before synchronising");

	// ====================
	// Covers for the main traffic.
	// ====================
	c_read: cover property ($fell(data_strobe_a_n) && read_not_write);
	c_write: cover property ($fell(data_strobe_a_n) && !read_not_write);
	c_addr: cover property ($fell(addr_strobe_n));
endmodule // host_port_monitor

// file: tb/host_port_pin_control_tb_top.sv
`timescale 1ns/100ps
// ====================
// Bench: AXI4-Lite drives the host end, which talks to the device end.
// ====================
module host_port_pin_control_tb_top;
	import host_port_pkg::*;
	typedef struct packed {
		logic ap;
		logic wr;
		logic [1:0] sel;
		logic half;
		logic [15:0] adr;
		logic [15:0] dat;
	} note_type; // One expected port transfer.
	logic aclk, aresetn, port_enable_strap, wide_mode_strap, outputs_off_n;
	logic irq_request, xfer_valid, xfer_write, xfer_half, port_enabled;
	logic wide_mode, pullup_enable, holder_enable;
	logic [1:0] xfer_select, bresp, rresp;
	logic [15:0] core_rdata, xfer_wdata, host_address_reg, mask;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, expect_xfer;
	logic [1:0] r;
	note_type notes[$]; // Transfers still awaited at the device.
	note_type got;
	int miscompares = 0, num_checks = 0, cycles = 0, i;
	int seed = 55967;

	host_port_if host_port_if_inst ();
	// Undriven wires rest at their pull-up level.
	assign host_port_if_inst.data_bus = host_port_if_inst.host_data_oe ?
		host_port_if_inst.host_data : host_port_if_inst.dev_data_oe ?
		host_port_if_inst.dev_data : 16'hFFFF;
	assign host_port_if_inst.ready_bus = host_port_if_inst.ready_oe ?
		host_port_if_inst.port_ready_out : 1'b1;
	assign host_port_if_inst.irq_bus = host_port_if_inst.irq_oe ?
		host_port_if_inst.host_irq_n : 1'b1;

	host_port_device host_port_device_inst (.aclk(aclk), .aresetn(aresetn),
		.pins(host_port_if_inst), .port_enable_strap(port_enable_strap),
		.wide_mode_strap(wide_mode_strap), .outputs_off_n(outputs_off_n),
		.irq_request(irq_request), .core_rdata(core_rdata),
		.xfer_valid(xfer_valid), .xfer_write(xfer_write),
		.xfer_select(xfer_select), .xfer_half(xfer_half),
		.xfer_wdata(xfer_wdata), .host_address_reg(host_address_reg),
		.port_enabled(port_enabled), .wide_mode(wide_mode),
		.pullup_enable(pullup_enable), .holder_enable(holder_enable));
	host_port_host host_port_host_inst (.aclk(aclk), .aresetn(aresetn),
		.pins(host_port_if_inst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	host_port_monitor host_port_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.outputs_off_n(outputs_off_n), .wide_mode(wide_mode),
		.host_select_n(host_port_if_inst.host_select_n),
		.data_strobe_a_n(host_port_if_inst.data_strobe_a_n),
		.addr_strobe_n(host_port_if_inst.addr_strobe_n),
		.read_not_write(host_port_if_inst.read_not_write),
		.dev_data_oe(host_port_if_inst.dev_data_oe),
		.port_ready_out(host_port_if_inst.port_ready_out),
		.ready_oe(host_port_if_inst.ready_oe),
		.host_irq_n(host_port_if_inst.host_irq_n),
		.irq_oe(host_port_if_inst.irq_oe),
		.ready_bus(host_port_if_inst.ready_bus));

	// Clock at 200 MHz.
	always #2.5 aclk = ~aclk;

	// A hang is cut short well past the longest expected run.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, want);
		end
	endtask

	// Each device transfer is matched against the oldest note.
	always @(posedge aclk) begin
		if (xfer_valid === 1'b1) begin
			if (notes.size() == 0) check(32'h1, 32'h0);
			else begin
				got = notes.pop_front();
				check(32'(xfer_write), 32'(got.wr));
				check(32'(xfer_select), 32'(got.sel));
				check(32'(xfer_half), 32'(got.half));
				if (got.wr) check(32'(xfer_wdata & mask), 32'(got.dat & mask));
				if (got.ap) check(32'(host_address_reg & mask), 32'(got.adr & mask));
			end
		end
	end

	// Master write: both channels offered together, each released when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		q = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Polls a status bit; the wait is bounded, not a fixed latency.
	task automatic wait_status(input int b, input logic want);
		for (int k = 0; k < 60; k++) begin
			axi_rd(STATUS_OFFSET);
			if (q[b] === want) break;
		end
		check(32'(q[b]), 32'(want));
	endtask

	task automatic start_reset(input logic en, input logic wide);
		aresetn <= 1'b0;
		port_enable_strap <= en;
		wide_mode_strap <= wide;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		expect_xfer = en;
		mask = wide ? 16'hFFFF : 16'h00FF;
	endtask

	// One port transfer; wide mode reports select and half as zero.
	task automatic xfer(input logic wr, ap, input logic [1:0] sel, input logic h);
		logic [31:0] a, d;
		a = $random(seed);
		d = $random(seed);
		core_rdata <= d[31:16];
		axi_wr(ADDRESS_OFFSET, a);
		axi_wr(WDATA_OFFSET, d);
		if (expect_xfer) notes.push_back({ap, wr, mask[8] ? 2'h0 : sel,
			mask[8] ? 1'b0 : h, a[15:0], d[15:0]});
		axi_wr(CONTROL_OFFSET, {26'h0, h, sel, ap, wr, 1'b1});
		wait_status(1, 1'b1);
		if (!wr && expect_xfer) begin
			axi_rd(RDATA_OFFSET);
			check(q & 32'(mask), 32'(d[31:16] & mask));
		end
	endtask

	// Main sequence.
	initial begin
		aclk = 0;
		aresetn = 0;
		{outputs_off_n, irq_request, core_rdata, awaddr, araddr, wdata} = 0;
		{awvalid, wvalid, bready, arvalid, rready} = 0;
		outputs_off_n = 1;
		start_reset(1'b1, 1'b0);
		axi_rd(STATUS_OFFSET);
		check(q, 32'h0000000C);
		axi_rd(8'h20);
		check(32'(r), 32'(AXI_SLVERR));
		axi_wr(8'h24, 32'h00000001);
		check(32'(r), 32'(AXI_SLVERR));
		for (i = 0; i < 8; i++) begin
			xfer(i[2], i[0] ^ i[1], i[1:0], 1'($random(seed)));
		end
		irq_request <= 1'b1;
		wait_status(3, 1'b0);
		outputs_off_n <= 1'b0;
		wait_status(3, 1'b1);
		outputs_off_n <= 1'b1;
		irq_request <= 1'b0;
		port_enable_strap <= 1'b0;
		xfer(1'b1, 1'b0, 2'h1, 1'b0);
		check(32'(port_enabled), 32'h1);
		start_reset(1'b1, 1'b1);
		check(32'(wide_mode), 32'h1);
		irq_request <= 1'b1;
		xfer(1'b1, 1'b1, 2'h3, 1'b1);
		xfer(1'b0, 1'b0, 2'h2, 1'b1);
		wait_status(3, 1'b1);
		irq_request <= 1'b0;
		start_reset(1'b0, 1'b0);
		check(32'(port_enabled), 32'h0);
		check(32'(pullup_enable), 32'h1);
		check(32'(holder_enable), 32'h1);
		xfer(1'b1, 1'b0, 2'h0, 1'b0);
		start_reset(1'b1, 1'b0);
		check(32'(pullup_enable), 32'h0);
		check(32'(wide_mode), 32'h0);
		give_verdict();
	end
endmodule // host_port_pin_control_tb_top
